/* rtl/asd_cmd_decoder.sv */
// Serial command decoder of a two-channel front end: bytes on the link
// clock, command execution and mode state on the master clock.
// Assumes serial data stable at falling link-clock edges, chip select
// low across each command, and a conversion-done pulse on mclk_i.
`include "asd_consts.svh"
`default_nettype none

module asd_cmd_decoder
   import asd_pkg::*;
#(
   parameter int MOD_DIV = `ASD_MOD_DIV,
   parameter int READY_LOW_CLK = `ASD_READY_LOW_CLK
) (
   // Master clock and reset
   input wire logic mclk_i,
   input wire logic reset_i,
   // Serial link from the host
   input wire logic sclk_i,
   input wire logic cs_n_i,
   input wire logic mosi_i,
   // Converter side
   input wire logic conv_done_i,
   output logic conv_run_o,
   output logic filter_reset_o,
   output logic result_load_o,
   output logic result_ready_n_o,
   // Mode state
   output logic standby_o,
   output logic continuous_o,
   output logic reset_busy_o,
   output logic offset_calibrate_o,
   output logic defaults_load_o,
   // Register access headers
   output logic reg_read_o,
   output logic reg_write_o,
   output logic [4:0] reg_addr_o,
   output logic [5:0] reg_count_o
);

   localparam int RESET_CLK = `ASD_RESET_MOD_PERIODS * MOD_DIV;
   localparam logic [7:0] RESET_LAST = 8'(RESET_CLK - 1);
   localparam logic [3:0] READY_LAST = 4'(READY_LOW_CLK - 1);

   // Link-clock side: framing and decode on falling sclk_i edges

   logic link_rst;
   logic [2:0] bit_cnt_q;
   logic [6:0] shift_q;
   asd_phase_t phase_q;
   asd_phase_t phase_d;
   logic hdr_write_q;
   logic [4:0] hdr_addr_q;
   logic [5:0] skip_q;
   logic [5:0] skip_d;
   asd_event_t ev_kind_q;
   asd_event_t ev_kind_d;
   logic [4:0] ev_addr_q;
   logic [4:0] ev_addr_d;
   logic [4:0] ev_count_q;
   logic ev_toggle_q;

   // Chip select high aborts a partial byte or command
   assign link_rst = reset_i | cs_n_i;

   logic [6:0] head7;
   logic [7:0] byte8;
   logic at7;
   logic at8;
   logic in_opcode;
   logic [2:0] top3;
   logic hdr_rd;
   logic hdr_wr;
   assign head7 = {shift_q[5:0], mosi_i};
   assign byte8 = {shift_q, mosi_i};
   assign at7 = (bit_cnt_q == `ASD_BIT_SEVENTH);
   assign at8 = (bit_cnt_q == `ASD_BIT_EIGHTH);
   assign in_opcode = (phase_q == ASD_PH_OPCODE);
   assign top3 = byte8[`ASD_HDR_TOP_MSB:`ASD_HDR_TOP_LSB];
   assign hdr_rd = at8 && in_opcode && (top3 == `ASD_HDR_READ);
   assign hdr_wr = at8 && in_opcode && (top3 == `ASD_HDR_WRITE);

   // Seventh-edge decode of the seven-bit heads
   asd_event_t ev7;
   always_comb begin
      case (head7)
         `ASD_OP7_WAKEUP: ev7 = ASD_EV_WAKEUP;
         `ASD_OP7_STANDBY: ev7 = ASD_EV_STANDBY;
         `ASD_OP7_RESET: ev7 = ASD_EV_RESET;
         `ASD_OP7_START: ev7 = ASD_EV_START;
         `ASD_OP7_STOP: ev7 = ASD_EV_STOP;
         `ASD_OP7_OFFSET_CAL: ev7 = ASD_EV_OFFSET_CAL;
         `ASD_OP7_READ_BY_CMD: ev7 = ASD_EV_READ_CMD;
         default: ev7 = ASD_EV_NONE;
      endcase
   end

   // Eighth-edge decode of full bytes and the count byte
   asd_event_t ev8;
   always_comb begin
      ev8 = ASD_EV_NONE;
      if (phase_q == ASD_PH_COUNT) begin
         ev8 = hdr_write_q ? ASD_EV_REG_WRITE : ASD_EV_REG_READ;
      end else if (in_opcode && byte8 == `ASD_OP_CONT_READ) begin
         ev8 = ASD_EV_CONT_READ;
      end else if (in_opcode && byte8 == `ASD_OP_STOP_CONT_READ) begin
         ev8 = ASD_EV_STOP_CONT;
      end
   end

   logic fire;
   assign ev_kind_d = at7 && in_opcode ? ev7 : (at8 ? ev8 : ASD_EV_NONE);
   assign fire = (ev_kind_d != ASD_EV_NONE);
   assign ev_addr_d = (phase_q == ASD_PH_COUNT) ? hdr_addr_q : 5'h00;

   // Byte phase: header, count byte, then skipped data bytes
   always_comb begin
      phase_d = phase_q;
      skip_d = skip_q;
      if (at8) begin
         case (phase_q)
            ASD_PH_OPCODE: begin
               if (hdr_rd || hdr_wr) begin
                  phase_d = ASD_PH_COUNT;
               end
            end
            ASD_PH_COUNT: begin
               phase_d = ASD_PH_DATA;
               skip_d = {1'b0, byte8[`ASD_FIELD_MSB:`ASD_FIELD_LSB]}
                        + 6'h01;
            end
            ASD_PH_DATA: begin
               skip_d = skip_q - 6'h01;
               if (skip_q == 6'h01) begin
                  phase_d = ASD_PH_OPCODE;
               end
            end
            default: phase_d = ASD_PH_OPCODE;
         endcase
      end
   end

   // Bit and byte framing; cleared whenever chip select rises
   always_ff @(negedge sclk_i or posedge link_rst) begin
      if (link_rst) begin
         bit_cnt_q <= 3'h0;
         shift_q <= 7'h00;
         phase_q <= ASD_PH_OPCODE;
         skip_q <= 6'h00;
      end else begin
         bit_cnt_q <= bit_cnt_q + 3'h1;
         shift_q <= byte8[6:0];
         phase_q <= phase_d;
         skip_q <= skip_d;
      end
   end

   // Header fields kept for the count byte
   always_ff @(negedge sclk_i or posedge link_rst) begin
      if (link_rst) begin
         hdr_write_q <= 1'b0;
         hdr_addr_q <= 5'h00;
      end else if (hdr_rd || hdr_wr) begin
         hdr_write_q <= hdr_wr;
         hdr_addr_q <= byte8[`ASD_FIELD_MSB:`ASD_FIELD_LSB];
      end
   end

   // Event word; survives chip select so no toggle is lost
   always_ff @(negedge sclk_i or posedge reset_i) begin
      if (reset_i) begin
         ev_kind_q <= ASD_EV_NONE;
         ev_addr_q <= 5'h00;
         ev_count_q <= 5'h00;
         ev_toggle_q <= 1'b0;
      end else if (fire) begin
         ev_kind_q <= ev_kind_d;
         ev_addr_q <= ev_addr_d;
         ev_count_q <= byte8[`ASD_FIELD_MSB:`ASD_FIELD_LSB];
         ev_toggle_q <= ~ev_toggle_q;
      end
   end

   // Master-clock side: command execution and mode state

   // Word is read after the toggle settles; the byte spacing the host
   // keeps leaves it steady far longer than the crossing takes
   logic ev_pulse;
   asd_toggle_sync u_ev_sync (
      .clk_i(mclk_i),
      .reset_i(reset_i),
      .toggle_i(ev_toggle_q),
      .pulse_o(ev_pulse)
   );

   logic standby_q;
   logic running_q;
   logic stop_pend_q;
   logic contin_q;
   logic busy_q;
   logic [7:0] rst_cnt_q;
   logic rdy_n_q;
   logic [3:0] low_cnt_q;

   // Standby accepts wake-up only; reset window accepts nothing
   logic take;
   logic c_wake, c_stby, c_rst, c_start, c_stop, c_cal;
   logic c_cont, c_scont, c_rdcmd, c_register_read_cmd, c_register_write_cmd;
   assign take = ev_pulse && !busy_q && (!standby_q
                 || ev_kind_q == ASD_EV_WAKEUP);
   assign c_wake = take && ev_kind_q == ASD_EV_WAKEUP;
   assign c_stby = take && ev_kind_q == ASD_EV_STANDBY;
   assign c_rst = take && ev_kind_q == ASD_EV_RESET;
   assign c_start = take && ev_kind_q == ASD_EV_START;
   assign c_stop = take && ev_kind_q == ASD_EV_STOP;
   assign c_cal = take && ev_kind_q == ASD_EV_OFFSET_CAL;
   assign c_cont = take && ev_kind_q == ASD_EV_CONT_READ;
   assign c_scont = take && ev_kind_q == ASD_EV_STOP_CONT;
   assign c_rdcmd = take && ev_kind_q == ASD_EV_READ_CMD;
   assign c_register_write_cmd = take && ev_kind_q == ASD_EV_REG_WRITE;
   assign c_register_read_cmd = take && ev_kind_q == ASD_EV_REG_READ
                   && !contin_q;

   // A start while running is dropped, no filter restart
   logic conv_begin;
   logic conv_end;
   assign conv_begin = c_start && !running_q;
   assign conv_end = running_q && conv_done_i;

   // Standby and readout mode
   always_ff @(posedge mclk_i or posedge reset_i) begin
      if (reset_i) begin
         standby_q <= 1'b0;
         contin_q <= 1'b1;
      end else if (c_rst) begin
         standby_q <= 1'b0;
         contin_q <= 1'b1;
      end else begin
         standby_q <= c_stby ? 1'b1 : (c_wake ? 1'b0 : standby_q);
         contin_q <= c_cont ? 1'b1 : (c_scont ? 1'b0 : contin_q);
      end
   end

   // Conversion run state; stop waits for the current result
   always_ff @(posedge mclk_i or posedge reset_i) begin
      if (reset_i) begin
         running_q <= 1'b0;
         stop_pend_q <= 1'b0;
      end else if (c_rst) begin
         running_q <= 1'b0;
         stop_pend_q <= 1'b0;
      end else begin
         running_q <= conv_begin | (running_q & ~(conv_end & stop_pend_q));
         // A stop that meets a result waits for the next one
         stop_pend_q <= running_q
                        & (c_stop | (stop_pend_q & ~conv_end));
      end
   end

   // Reset command busy window of nine modulator periods
   always_ff @(posedge mclk_i or posedge reset_i) begin
      if (reset_i) begin
         busy_q <= 1'b0;
         rst_cnt_q <= 8'h00;
      end else if (c_rst) begin
         busy_q <= 1'b1;
         rst_cnt_q <= 8'h00;
      end else if (busy_q) begin
         busy_q <= (rst_cnt_q != RESET_LAST);
         rst_cnt_q <= rst_cnt_q + 8'h01;
      end
   end

   // Result-ready: high at start, low for a few clocks per result
   logic low_run;
   assign low_run = !rdy_n_q && low_cnt_q != READY_LAST;
   always_ff @(posedge mclk_i or posedge reset_i) begin
      if (reset_i) begin
         rdy_n_q <= 1'b1;
         low_cnt_q <= 4'h0;
      end else if (conv_begin || c_rst) begin
         rdy_n_q <= 1'b1;
         low_cnt_q <= 4'h0;
      end else if (conv_end) begin
         rdy_n_q <= 1'b0;
         low_cnt_q <= 4'h0;
      end else begin
         rdy_n_q <= !low_run;
         low_cnt_q <= low_run ? low_cnt_q + 4'h1 : 4'h0;
      end
   end

   // Registered strobes and header fields toward the core
   always_ff @(posedge mclk_i or posedge reset_i) begin
      if (reset_i) begin
         filter_reset_o <= 1'b0;
         defaults_load_o <= 1'b0;
         offset_calibrate_o <= 1'b0;
         result_load_o <= 1'b0;
         reg_read_o <= 1'b0;
         reg_write_o <= 1'b0;
         reg_addr_o <= 5'h00;
         reg_count_o <= 6'h00;
      end else begin
         filter_reset_o <= c_rst | conv_begin;
         defaults_load_o <= c_rst;
         offset_calibrate_o <= c_cal;
         // Stopped mode reloads only on read-once, so a late result
         // cannot disturb a read already under way
         result_load_o <= c_rdcmd | (conv_end & contin_q);
         reg_read_o <= c_register_read_cmd;
         reg_write_o <= c_register_write_cmd;
         if (c_register_read_cmd || c_register_write_cmd) begin
            reg_addr_o <= ev_addr_q;
            reg_count_o <= {1'b0, ev_count_q} + 6'h01;
         end
      end
   end

   // Level outputs straight from state flops
   assign conv_run_o = running_q;
   assign standby_o = standby_q;
   assign continuous_o = contin_q;
   assign reset_busy_o = busy_q;
   assign result_ready_n_o = rdy_n_q;

endmodule : asd_cmd_decoder

`default_nettype wire

/* shared/asd_consts.svh */
// Constants of the serial command decoder: opcode patterns and timing.
// Assumes inclusion by bare name from files that need these figures.
`ifndef ASD_CONSTS_SVH
`define ASD_CONSTS_SVH

// Seven-bit heads of opcodes decided on the seventh falling edge
`define ASD_OP7_WAKEUP 7'h01
`define ASD_OP7_STANDBY 7'h02
`define ASD_OP7_RESET 7'h03
`define ASD_OP7_START 7'h04
`define ASD_OP7_STOP 7'h05
`define ASD_OP7_OFFSET_CAL 7'h0D
`define ASD_OP7_READ_BY_CMD 7'h09

// Full bytes decided on the eighth falling edge
`define ASD_OP_CONT_READ 8'h10
`define ASD_OP_STOP_CONT_READ 8'h11

// Header prefixes, top three bits of the first byte
`define ASD_HDR_READ 3'h1
`define ASD_HDR_WRITE 3'h2

// Field positions in header bytes
`define ASD_HDR_TOP_MSB 7
`define ASD_HDR_TOP_LSB 5
`define ASD_FIELD_MSB 4
`define ASD_FIELD_LSB 0

// Bit index of the last bit for seventh and eighth edge
`define ASD_BIT_SEVENTH 3'h6
`define ASD_BIT_EIGHTH 3'h7

// Master clock periods per modulator period, default
`define ASD_MOD_DIV 4
// Modulator periods taken by the reset command
`define ASD_RESET_MOD_PERIODS 9
// Master clock periods the result-ready line stays low
`define ASD_READY_LOW_CLK 4

`endif

/* shared/asd_pkg.sv */
// Types shared by the serial command decoder.
// Assumes nothing beyond a SystemVerilog compiler.
`default_nettype none

package asd_pkg;

   // Command kinds passed from the serial side to the core
   typedef enum logic [3:0] {
      ASD_EV_NONE       = 4'h0,
      ASD_EV_WAKEUP     = 4'h1,
      ASD_EV_STANDBY    = 4'h2,
      ASD_EV_RESET      = 4'h3,
      ASD_EV_START      = 4'h4,
      ASD_EV_STOP       = 4'h5,
      ASD_EV_OFFSET_CAL = 4'h6,
      ASD_EV_CONT_READ  = 4'h7,
      ASD_EV_STOP_CONT  = 4'h8,
      ASD_EV_READ_CMD   = 4'h9,
      ASD_EV_REG_READ   = 4'hA,
      ASD_EV_REG_WRITE  = 4'hB
   } asd_event_t;

   // Byte phase of the serial receiver
   typedef enum logic [1:0] {
      ASD_PH_OPCODE = 2'b00,
      ASD_PH_COUNT  = 2'b01,
      ASD_PH_DATA   = 2'b10
   } asd_phase_t;

endpackage : asd_pkg

`default_nettype wire

/* rtl/asd_toggle_sync.sv */
// Toggle-to-pulse crossing into the destination clock domain.
// Assumes the source toggles at most once per three destination cycles.
`default_nettype none

module asd_toggle_sync (
   // Destination clock and reset
   input wire logic clk_i,
   input wire logic reset_i,
   // Toggle from the other domain
   input wire logic toggle_i,
   // One-cycle pulse per toggle
   output logic pulse_o
);

   logic meta_q;
   logic sync_q;
   logic last_q;

   // First stage feeds only the second stage
   always_ff @(posedge clk_i or posedge reset_i) begin
      if (reset_i) begin
         meta_q <= 1'b0;
         sync_q <= 1'b0;
         last_q <= 1'b0;
      end else begin
         meta_q <= toggle_i;
         sync_q <= meta_q;
         last_q <= sync_q;
      end
   end

   // Edge of the settled level marks the event
   assign pulse_o = sync_q ^ last_q;

endmodule : asd_toggle_sync

`default_nettype wire

/* tb/asd_host_model.sv */
// Host side of the serial link: a bus master sending command bytes.
// Assumes the decoder samples data on the falling link-clock edge.
`default_nettype none

module asd_host_model (
   // Link outputs towards the decoder
   output logic sclk_o,
   output logic cs_n_o,
   output logic mosi_o
);
   timeunit 1ns;
   timeprecision 1ps;

   // Link idles with clock still and select high
   initial begin
      sclk_o = 1'b0;
      cs_n_o = 1'b1;
      mosi_o = 1'b0;
   end

   // One byte, MSB first, 160 ns link period; last raises select.
   // Setup delay wanders so link edges drift against the master clock
   task automatic send(input logic [7:0] b, input int nbits,
                       input bit last);
      cs_n_o = 1'b0;
      #(76 + $urandom_range(8));
      for (int i = 7; i > 7 - nbits; i--) begin
         mosi_o = b[i];
         sclk_o = 1'b1;
         #80;
         sclk_o = 1'b0;
         #80;
      end
      // Stale data would hide a late sample, so invert it
      mosi_o = ~mosi_o;
      #160;
      if (last)
         cs_n_o = 1'b1;
   endtask : send
endmodule : asd_host_model

`default_nettype wire

/* tb/asd_cmd_monitor.sv */
// Checker of the command decoder ports.
// Assumes it is bound into every asd_cmd_decoder instance.
`default_nettype none

module asd_cmd_monitor #(
   parameter int MOD_DIV = 4,
   parameter int READY_LOW_CLK = 4
) (
   // Clock, reset and converter input
   input wire logic mclk_i,
   input wire logic reset_i,
   input wire logic conv_done_i,
   // Watched outputs
   input wire logic conv_run_o,
   input wire logic filter_reset_o,
   input wire logic result_load_o,
   input wire logic result_ready_n_o,
   input wire logic standby_o,
   input wire logic continuous_o,
   input wire logic reset_busy_o,
   input wire logic defaults_load_o,
   input wire logic reg_read_o,
   input wire logic reg_write_o,
   input wire logic [5:0] reg_count_o
);
   int busy_q;

   // Length of the reset window, cleared when it ends
   always_ff @(posedge mclk_i or posedge reset_i) begin
      if (reset_i)
         busy_q <= 0;
      else if (reset_busy_o)
         busy_q <= busy_q + 1;
      else
         busy_q <= 0;
   end

   default clocking cb @(posedge mclk_i); endclocking
   default disable iff (reset_i);

   a_busy_length: assert property ($fell(reset_busy_o) |->
      busy_q == 9 * MOD_DIV) else $error("reset window length");
   a_reset_state: assert property ($rose(reset_busy_o) |->
      defaults_load_o && continuous_o && !standby_o && !conv_run_o)
      else $error("reset command state");
   a_ready_width: assert property ($fell(result_ready_n_o) |->
      ##1 !result_ready_n_o [*3] ##1 result_ready_n_o)
      else $error("ready low width");
   a_done_ready: assert property (conv_done_i && conv_run_o |=>
      !result_ready_n_o) else $error("ready not low after result");
   a_cont_load: assert property (conv_done_i && conv_run_o &&
      continuous_o |=> result_load_o) else $error("no load in readout");
   a_start_marks: assert property ($rose(conv_run_o) |->
      filter_reset_o && result_ready_n_o) else $error("start marks");
   a_stop_on_done: assert property ($fell(conv_run_o) |->
      $past(conv_done_i) || defaults_load_o)
      else $error("halt before conversion end");
   a_read_refused: assert property (reg_read_o |->
      !continuous_o) else $error("register read in readout mode");
   a_count_range: assert property (reg_read_o || reg_write_o |->
      reg_count_o inside {[1:32]} && !(reg_read_o && reg_write_o))
      else $error("header count or kind");
endmodule : asd_cmd_monitor

bind asd_cmd_decoder asd_cmd_monitor #(
   .MOD_DIV(MOD_DIV),
   .READY_LOW_CLK(READY_LOW_CLK)
) mon_u (
   .mclk_i(mclk_i),
   .reset_i(reset_i),
   .conv_done_i(conv_done_i),
   .conv_run_o(conv_run_o),
   .filter_reset_o(filter_reset_o),
   .result_load_o(result_load_o),
   .result_ready_n_o(result_ready_n_o),
   .standby_o(standby_o),
   .continuous_o(continuous_o),
   .reset_busy_o(reset_busy_o),
   .defaults_load_o(defaults_load_o),
   .reg_read_o(reg_read_o),
   .reg_write_o(reg_write_o),
   .reg_count_o(reg_count_o)
);

`default_nettype wire

/* tb/asd_cmd_decoder_tb_top.sv */
// Self-checking bench of the command decoder with a host model.
// Assumes the monitor is bound and the host model is compiled first.
`default_nettype none

module asd_cmd_decoder_tb_top;
   timeunit 1ns;
   timeprecision 1ps;

   logic mclk_i, reset_i, conv_done_i;
   wire logic sclk, cs_n, mosi;
   logic run, frst, load, rdy_n, stby, cont, busy, cal, defl, rd, wr;
   logic [4:0] addr, h_addr;
   logic [5:0] cnt, h_cnt;
   int bad_count = 0, checks = 0;
   int n_frst = 0, n_load = 0, n_rd = 0, n_wr = 0, n_cal = 0, n_def = 0;

   // Master clock, 8 ns
   initial begin
      mclk_i = 1'b0;
      forever #4 mclk_i = ~mclk_i;
   end

   asd_host_model host_u (.sclk_o(sclk), .cs_n_o(cs_n), .mosi_o(mosi));

   asd_cmd_decoder dut_u (
      .mclk_i(mclk_i), .reset_i(reset_i), .sclk_i(sclk), .cs_n_i(cs_n),
      .mosi_i(mosi), .conv_done_i(conv_done_i), .conv_run_o(run),
      .filter_reset_o(frst), .result_load_o(load),
      .result_ready_n_o(rdy_n), .standby_o(stby), .continuous_o(cont),
      .reset_busy_o(busy), .offset_calibrate_o(cal),
      .defaults_load_o(defl), .reg_read_o(rd), .reg_write_o(wr),
      .reg_addr_o(addr), .reg_count_o(cnt)
   );

   // Strobe counts; header fields held at their strobe
   always @(posedge mclk_i) begin
      if (frst === 1'b1) n_frst++;
      if (load === 1'b1) n_load++;
      if (rd === 1'b1) n_rd++;
      if (wr === 1'b1) n_wr++;
      if (cal === 1'b1) n_cal++;
      if (defl === 1'b1) n_def++;
      if (rd === 1'b1 || wr === 1'b1) begin
         h_addr = addr;
         h_cnt = cnt;
      end
   end

   function automatic logic [7:0] exp_count(input logic [7:0] b);
      return {3'h0, b[4:0]} + 8'h01;
   endfunction : exp_count

   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      checks++;
      if (got !== exp) begin
         bad_count++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk

   // Gap covers the decode delay and the host waits after commands
   task automatic cmd(input logic [7:0] b);
      host_u.send(b, 8, 1'b1);
      repeat (12) @(negedge mclk_i);
   endtask : cmd

   // Header, count byte, then count+1 skipped data bytes
   task automatic hdr(input logic [7:0] b0, input logic [7:0] b1);
      host_u.send(b0, 8, 1'b0);
      host_u.send(b1, 8, 1'b0);
      for (int i = 0; i <= b1[4:0]; i++)
         host_u.send(8'($urandom), 8, i == b1[4:0]);
      repeat (12) @(negedge mclk_i);
   endtask : hdr

   task automatic done_pulse;
      @(negedge mclk_i) conv_done_i = 1'b1;
      @(negedge mclk_i) conv_done_i = 1'b0;
      chk(8'(rdy_n), 8'h00);
      repeat (8) @(negedge mclk_i);
   endtask : done_pulse

   task automatic print_verdict;
      $display("checks %0d mismatches %0d", checks, bad_count);
      if (bad_count == 0 && checks > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask : print_verdict

   // Watchdog well beyond the expected run of about 80 us
   initial begin
      #500000;
      bad_count++;
      print_verdict();
   end

   initial begin
      logic [7:0] a, n;
      int base;
      conv_done_i = 1'b0;
      reset_i = 1'b1;
      void'($urandom(50));
      repeat (2) @(negedge mclk_i);
      reset_i = 1'b0;
      repeat (4) @(negedge mclk_i);
      chk(8'(cont), 8'h01);
      chk(8'(rdy_n), 8'h01);
      hdr(8'h25, 8'h01);
      chk(8'(n_rd), 8'h00);
      cmd(8'h11);
      chk(8'(cont), 8'h00);
      // Random read and write headers with small counts
      for (int i = 0; i < 6; i++) begin
         a = 8'($urandom_range(31));
         n = 8'($urandom_range(3));
         base = i[0] ? n_wr : n_rd;
         hdr({i[0] ? 3'h2 : 3'h1, a[4:0]}, n);
         chk(8'(i[0] ? n_wr : n_rd), 8'(base + 1));
         chk({3'h0, h_addr}, a);
         chk({2'h0, h_cnt}, exp_count(n));
      end
      // Header cut after seven count bits is dropped
      base = n_wr;
      host_u.send(8'h41, 8, 1'b0);
      host_u.send(8'h00, 7, 1'b1);
      repeat (12) @(negedge mclk_i);
      chk(8'(n_wr), 8'(base));
      base = n_frst;
      cmd(8'h08);
      chk(8'(run), 8'h01);
      cmd(8'h08);
      chk(8'(n_frst), 8'(base + 1));
      base = n_load;
      done_pulse();
      chk(8'(n_load), 8'(base));
      cmd(8'h12);
      chk(8'(n_load), 8'(base + 1));
      // Stop taken on the seventh edge, waits for the result
      host_u.send(8'h0A, 7, 1'b1);
      repeat (12) @(negedge mclk_i);
      chk(8'(run), 8'h01);
      done_pulse();
      chk(8'(run), 8'h00);
      cmd(8'h0A);
      chk(8'(run), 8'h00);
      // Start goes first: readout mode loads each result; calibration runs after readout ends
      cmd(8'h08);
      cmd(8'h10);
      chk(8'(cont), 8'h01);
      base = n_load;
      done_pulse();
      chk(8'(n_load), 8'(base + 1));
      cmd(8'h11);
      base = n_cal;
      cmd(8'h1A);
      chk(8'(n_cal), 8'(base + 1));
      // Unmatched bytes leave everything alone
      base = n_frst + n_cal + n_def + n_load + n_rd + n_wr;
      cmd(8'hFF);
      cmd(8'h00);
      cmd(8'h80);
      chk(8'(n_frst + n_cal + n_def + n_load + n_rd + n_wr),
          8'(base));
      chk({6'h00, run, stby}, 8'h02);
      // Standby takes only wake-up
      cmd(8'h04);
      chk(8'(stby), 8'h01);
      cmd(8'h0A);
      chk(8'(run), 8'h01);
      cmd(8'h02);
      chk(8'(stby), 8'h00);
      // Busy window is short, so look while it stands
      base = n_def;
      fork
         host_u.send(8'h06, 8, 1'b1);
         begin
            @(posedge busy);
            @(negedge mclk_i);
            chk({5'h00, busy, run, cont}, 8'h05);
         end
      join
      repeat (12) @(negedge mclk_i);
      chk(8'(n_def), 8'(base + 1));
      repeat (30) @(negedge mclk_i);
      chk(8'(busy), 8'h00);
      // Reset with conversion stopped restores readout mode
      cmd(8'h11);
      reset_i = 1'b1;
      @(negedge mclk_i);
      chk(8'(cont), 8'h01);
      reset_i = 1'b0;
      repeat (4) @(negedge mclk_i);
      chk({5'h00, stby, run, rdy_n}, 8'h01);
      cmd(8'h11);
      chk(8'(cont), 8'h00);
      print_verdict();
   end
endmodule : asd_cmd_decoder_tb_top

`default_nettype wire
